// [hw/pcsfa_top.sv]
`timescale 1ns/100ps
`include "pcsfa_cfg.svh"

// Contract
// RULE_01 - program store is 4096 words of 12 bits, addressed by a binary counter
// RULE_02 - reset loads the program counter with 0FFFh
// RULE_03 - without a branch the counter increments and wraps from maximum to zero
// RULE_04 - pages are 512 words; counting crosses page edges with no effect
// RULE_05 - counter low byte is global register 02h; bit 8 hidden; top bits from page select
// RULE_06 - jump and call take upper target bits from page select; page instruction sets them
// RULE_07 - call stack is eight 12-bit entries; call pushes and shifts, return pops
// RULE_08 - the stack is separate from data memory and never directly readable or writable
// RULE_09 - data memory is sixteen banks of sixteen bytes plus a sixteen-byte global bank
// RULE_10 - every data access carries a 5-bit designator that picks the operand
// RULE_11 - designator 00h indirect, 01h-0Fh direct, 10h-1Fh semi-direct
// RULE_12 - indirect mode uses the full 8-bit pointer at 04h; bank 0 unreachable
// RULE_13 - indirect pointer 01h-0Fh reaches global bank, higher values banks 1 to F
// RULE_14 - direct mode: designator selects a global register, pointer ignored
// RULE_15 - semi-direct: pointer high nibble plus designator low nibble; global unreachable
// RULE_16 - global location 00 is not storage but the indirect access port
// RULE_17 - bank instruction writes pointer bits 4 to 6 only
// RULE_18 - pointer bit 7 picks lower banks 00-7F or upper banks 80-FF
// RULE_19 - stack overflow drops the oldest entry; empty pop returns the bottom entry

module pcsfa_top (
    // clock and reset
    input  logic        CLK,
    input  logic        RST,
    // program flow events from decode
    input  logic        PC_STEP,
    input  logic        JUMP,
    input  logic        CALL,
    input  logic        RET,
    input  logic [8:0]  BRANCH_ADDR,
    // page and bank instructions
    input  logic        PAGE_WR,
    input  logic [2:0]  PAGE_VAL,
    input  logic        BANK_WR,
    input  logic [2:0]  BANK_VAL,
    // operand access
    input  logic [4:0]  DESIG,
    input  logic        RD_REQ,
    input  logic        WR_REQ,
    input  logic [7:0]  WR_DATA,
    output logic [7:0]  RD_DATA,
    output logic        RD_VALID,
    // address state
    output logic [11:0] PC_ADDR,
    output logic [2:0]  PAGE_SEL,
    output logic [7:0]  BANK_PTR
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pcsfa_pkg::pcsfa_pc_t   pc;
    pcsfa_pkg::pcsfa_pc_t   next_pc;
    pcsfa_pkg::pcsfa_pc_t   pc_inc;
    logic [2:0]             page;
    logic [2:0]             next_page;
    pcsfa_pkg::pcsfa_byte_t bank_select_pointer;
    pcsfa_pkg::pcsfa_byte_t next_bank_select_pointer;
    pcsfa_pkg::pcsfa_pc_t   stack      [`PCSFA_STACK_DEPTH];
    pcsfa_pkg::pcsfa_pc_t   next_stack [`PCSFA_STACK_DEPTH];
    logic                   push;
    logic                   pop;

    // operand decode
    pcsfa_pkg::pcsfa_mode_t mode;
    pcsfa_pkg::pcsfa_tgt_t  tgt;
    logic [3:0]             glob_idx;
    logic                   is_global;
    logic [7:0]             bank_addr;
    logic [8:0]             mem_addr;
    pcsfa_pkg::pcsfa_byte_t sreg_val;

    // read pipeline
    logic                   rd_valid;
    logic                   next_rd_valid;
    logic                   rd_from_mem;
    logic                   next_rd_from_mem;
    pcsfa_pkg::pcsfa_byte_t sreg_q;
    pcsfa_pkg::pcsfa_byte_t next_sreg_q;

    pcsfa_mem_if            mem_bus ();

    // ----------------------------------------------------------------
    // operand address decode
    // ----------------------------------------------------------------

    // mode follows from the designator alone
    always_comb
    begin
        if (DESIG == 5'h00)
        begin
            mode = pcsfa_pkg::MODE_INDIRECT;                        // RULE_11
        end
        else if (DESIG[`PCSFA_DESIG_SEMI_BIT])
        begin
            mode = pcsfa_pkg::MODE_SEMI;                            // RULE_11
        end
        else
        begin
            mode = pcsfa_pkg::MODE_DIRECT;                          // RULE_11
        end
    end

    // resolve the operand to a global slot or a banked byte
    always_comb
    begin
        is_global = 1'b0;
        glob_idx  = 4'h0;
        bank_addr = 8'h00;
        unique case (mode)
            pcsfa_pkg::MODE_INDIRECT:
            begin
                // pointer high nibble zero means global, so bank 0 is never hit
                if (bank_select_pointer[7:4] == 4'h0)
                begin
                    is_global = 1'b1;                               // RULE_13
                    glob_idx  = bank_select_pointer[3:0];           // RULE_12
                end
                else
                begin
                    bank_addr = bank_select_pointer;                // RULE_12
                end
            end
            pcsfa_pkg::MODE_DIRECT:
            begin
                is_global = 1'b1;                                   // RULE_14
                glob_idx  = DESIG[3:0];
            end
            pcsfa_pkg::MODE_SEMI:
            begin
                // bit 7 rides along in the high nibble and picks the block
                bank_addr = {bank_select_pointer[7:4], DESIG[3:0]}; // RULE_15
            end
        endcase
    end

    // banked bytes sit at 00-FF, general globals above them
    always_comb
    begin
        if (is_global)
        begin
            mem_addr = `PCSFA_GLOBAL_BASE | {5'h00, glob_idx};      // RULE_09
        end
        else
        begin
            mem_addr = {1'b0, bank_addr};                           // RULE_18
        end
    end

    // special globals are held here, the rest in storage
    always_comb
    begin
        tgt = pcsfa_pkg::TGT_MEM;
        if (is_global)
        begin
            unique case (glob_idx)
                // indirect through a pointer of zero lands on the port itself
                `PCSFA_OFS_INDIRECT: tgt = pcsfa_pkg::TGT_NONE;     // RULE_16
                `PCSFA_OFS_PC_LOW:   tgt = pcsfa_pkg::TGT_PC;       // RULE_05
                `PCSFA_OFS_STATUS:   tgt = pcsfa_pkg::TGT_STATUS;
                `PCSFA_OFS_PTR:      tgt = pcsfa_pkg::TGT_PTR;      // RULE_12
                default:             tgt = pcsfa_pkg::TGT_MEM;
            endcase
        end
    end

    // value shown when a special global is read
    always_comb
    begin
        unique case (tgt)
            pcsfa_pkg::TGT_PC:     sreg_val = pc[7:0];              // RULE_05
            pcsfa_pkg::TGT_STATUS: sreg_val = {page, 5'h00};
            pcsfa_pkg::TGT_PTR:    sreg_val = bank_select_pointer;
            default:               sreg_val = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // storage port
    // ----------------------------------------------------------------

    // the stack has no address here, so data accesses can never reach it
    assign mem_bus.addr  = mem_addr;                                // RULE_08
    assign mem_bus.wr_en = WR_REQ && (tgt == pcsfa_pkg::TGT_MEM);   // RULE_10
    assign mem_bus.rd_en = RD_REQ && (tgt == pcsfa_pkg::TGT_MEM);
    assign mem_bus.wdata = WR_DATA;

    pcsfa_dmem u_dmem (
        .clk  (CLK),
        .rst  (RST),
        .port (mem_bus.mem)
    );

    // ----------------------------------------------------------------
    // read return
    // ----------------------------------------------------------------

    // special values are captured now so they line up with storage data
    always_comb
    begin
        next_rd_valid    = RD_REQ;
        next_rd_from_mem = rd_from_mem;
        next_sreg_q      = sreg_q;
        if (RD_REQ)
        begin
            next_rd_from_mem = (tgt == pcsfa_pkg::TGT_MEM);
            next_sreg_q      = sreg_val;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rd_valid    <= 1'b0;
            rd_from_mem <= 1'b0;
            sreg_q      <= 8'h00;
        end
        else
        begin
            rd_valid    <= next_rd_valid;
            rd_from_mem <= next_rd_from_mem;
            sreg_q      <= next_sreg_q;
        end
    end

    assign RD_DATA  = rd_from_mem ? mem_bus.rdata : sreg_q;
    assign RD_VALID = rd_valid;

    // ----------------------------------------------------------------
    // bank select pointer
    // ----------------------------------------------------------------

    // a bank instruction overrides bits 4 to 6 of a full write in the same cycle
    always_comb
    begin
        next_bank_select_pointer = bank_select_pointer;
        if (WR_REQ && (tgt == pcsfa_pkg::TGT_PTR))
        begin
            next_bank_select_pointer = WR_DATA;                     // RULE_18
        end
        if (BANK_WR)
        begin
            next_bank_select_pointer[`PCSFA_BANK_LSB +: `PCSFA_BANK_W] = BANK_VAL; // RULE_17
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            bank_select_pointer <= `PCSFA_PTR_RESET;
        end
        else
        begin
            bank_select_pointer <= next_bank_select_pointer;
        end
    end

    // ----------------------------------------------------------------
    // program counter and page select
    // ----------------------------------------------------------------

    // natural 12-bit wrap; page edges are just carries
    assign pc_inc = pc + 12'h001;                                   // RULE_03 RULE_04

    // return beats call beats jump beats a data write beats a step
    always_comb
    begin
        next_pc = pc;
        push    = 1'b0;
        pop     = 1'b0;
        if (RET)
        begin
            pop     = 1'b1;
            next_pc = stack[0];                                     // RULE_07
        end
        else if (CALL)
        begin
            push    = 1'b1;
            // call targets always start in the lower half of a page
            next_pc = {page, 1'b0, BRANCH_ADDR[7:0]};               // RULE_06
        end
        else if (JUMP)
        begin
            next_pc = {page, BRANCH_ADDR};                          // RULE_06
        end
        else if (WR_REQ && (tgt == pcsfa_pkg::TGT_PC))
        begin
            // bit 8 is not writable and clears on a direct load
            next_pc = {page, 1'b0, WR_DATA};                        // RULE_05
        end
        else if (PC_STEP)
        begin
            next_pc = pc_inc;                                       // RULE_03 RULE_01
        end
    end

    // page bits move by the page instruction or a status write
    always_comb
    begin
        next_page = page;
        if (PAGE_WR)
        begin
            next_page = PAGE_VAL;                                   // RULE_06
        end
        else if (WR_REQ && (tgt == pcsfa_pkg::TGT_STATUS))
        begin
            next_page = WR_DATA[`PCSFA_STATUS_PAGE_LSB +: `PCSFA_PAGE_W]; // RULE_05
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pc   <= `PCSFA_PC_RESET;                                // RULE_02
            page <= `PCSFA_PAGE_RESET;
        end
        else
        begin
            pc   <= next_pc;
            page <= next_page;
        end
    end

    // ----------------------------------------------------------------
    // call stack
    // ----------------------------------------------------------------

    // pure shift register: no pointer, so no overflow or underflow state
    for (genvar i = 0; i < `PCSFA_STACK_DEPTH; i++)
    begin : g_stack
        always_comb
        begin
            next_stack[i] = stack[i];
            if (pop)
            begin
                if (i == `PCSFA_STACK_DEPTH - 1)
                begin
                    next_stack[i] = stack[i];                       // RULE_19
                end
                else
                begin
                    next_stack[i] = stack[(i + 1) % `PCSFA_STACK_DEPTH]; // RULE_07
                end
            end
            else if (push)
            begin
                if (i == 0)
                begin
                    next_stack[i] = pc_inc;                         // RULE_07
                end
                else
                begin
                    // the oldest entry falls off the bottom
                    next_stack[i] = stack[(i + `PCSFA_STACK_DEPTH - 1) % `PCSFA_STACK_DEPTH]; // RULE_19
                end
            end
        end

        always_ff @(posedge CLK)
        begin
            if (RST)
            begin
                stack[i] <= 12'h000;
            end
            else
            begin
                stack[i] <= next_stack[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign PC_ADDR  = pc;
    assign PAGE_SEL = page;
    assign BANK_PTR = bank_select_pointer;

endmodule : pcsfa_top

// [pkg/pcsfa_cfg.svh]
`ifndef PCSFA_CFG_SVH
`define PCSFA_CFG_SVH

// ----------------------------------------------------------------
// program counter and page select
// ----------------------------------------------------------------
`define PCSFA_PC_W          12
`define PCSFA_PC_RESET      12'hFFF
`define PCSFA_PAGE_W        3
`define PCSFA_PAGE_LSB      9
`define PCSFA_PAGE_RESET    3'h0
`define PCSFA_STATUS_PAGE_LSB 5
`define PCSFA_STACK_DEPTH   8

// ----------------------------------------------------------------
// data memory layout
// ----------------------------------------------------------------
`define PCSFA_DATA_W        8
`define PCSFA_DESIG_W       5
`define PCSFA_DESIG_SEMI_BIT 4
`define PCSFA_BANK_LSB      4
`define PCSFA_BANK_W        3
`define PCSFA_BLOCK_BIT     7
`define PCSFA_MADDR_W       9
`define PCSFA_DMEM_DEPTH    272
`define PCSFA_GLOBAL_BASE   9'h100

// ----------------------------------------------------------------
// global bank offsets and reset values
// ----------------------------------------------------------------
`define PCSFA_OFS_INDIRECT  4'h0
`define PCSFA_OFS_PC_LOW    4'h2
`define PCSFA_OFS_STATUS    4'h3
`define PCSFA_OFS_PTR       4'h4
`define PCSFA_PTR_RESET     8'h00

`endif

// [pkg/pcsfa_pkg.sv]
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package pcsfa_pkg;

    typedef logic [11:0] pcsfa_pc_t;
    typedef logic [7:0]  pcsfa_byte_t;

    // operand addressing mode picked by the designator
    typedef enum logic [1:0] {MODE_INDIRECT, MODE_DIRECT, MODE_SEMI} pcsfa_mode_t;

    // where an operand access really lands
    typedef enum logic [2:0] {TGT_NONE, TGT_PC, TGT_STATUS, TGT_PTR, TGT_MEM} pcsfa_tgt_t;

endpackage : pcsfa_pkg

// [pkg/pcsfa_mem_if.sv]
`timescale 1ns/100ps

// ----------------------------------------------------------------
// port between address logic and the register storage
// ----------------------------------------------------------------
interface pcsfa_mem_if;
    logic [8:0]  addr;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport ctrl (output addr, output wr_en, output rd_en, output wdata, input rdata);
    modport mem  (input addr, input wr_en, input rd_en, input wdata, output rdata);
endinterface : pcsfa_mem_if

// [hw/pcsfa_dmem.sv]
`timescale 1ns/100ps
`include "pcsfa_cfg.svh"

// ----------------------------------------------------------------
// register storage: sixteen banks plus the general global registers
// ----------------------------------------------------------------
module pcsfa_dmem (
    // clock and reset
    input  logic              clk,
    input  logic              rst,
    // access port
    pcsfa_mem_if.mem          port
);

    logic [`PCSFA_DATA_W-1:0] store [`PCSFA_DMEM_DEPTH];
    logic [`PCSFA_DATA_W-1:0] rdata_q;

    // contents are not cleared; software initialises its registers
    always_ff @(posedge clk)
    begin
        if (port.wr_en)
        begin
            store[port.addr] <= port.wdata;
        end
    end

    // read data leaves from a register, one cycle after the request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata_q <= 8'h00;
        end
        else if (port.rd_en)
        begin
            rdata_q <= store[port.addr];
        end
    end

    assign port.rdata = rdata_q;

endmodule : pcsfa_dmem

// [tb/pcsfa_top_props.sv]
`timescale 1ns/100ps

// ------------------------------------------------
// port checker for counter, page, read valid and pointer
// ------------------------------------------------
module pcsfa_top_props (
    // clock and reset
    input logic        CLK,
    input logic        RST,
    // flow and access inputs
    input logic        PC_STEP,
    input logic        JUMP,
    input logic        CALL,
    input logic        RET,
    input logic [8:0]  BRANCH_ADDR,
    input logic        PAGE_WR,
    input logic [2:0]  PAGE_VAL,
    input logic        BANK_WR,
    input logic [2:0]  BANK_VAL,
    input logic [4:0]  DESIG,
    input logic        RD_REQ,
    input logic        WR_REQ,
    input logic [7:0]  WR_DATA,
    // observed state
    input logic        RD_VALID,
    input logic [11:0] PC_ADDR,
    input logic [2:0]  PAGE_SEL,
    input logic [7:0]  BANK_PTR
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // the counter low byte can also be written through the pointer
    logic pc_wr;
    logic no_br;
    assign pc_wr = WR_REQ && (DESIG == 5'h02 || (DESIG == 5'h00 && BANK_PTR == 8'h02));
    assign no_br = !JUMP && !CALL && !RET;

    property p_reset_vals;
        $fell(RST) |-> PC_ADDR == 12'hFFF && PAGE_SEL == 3'h0 && BANK_PTR == 8'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
    property p_step;
        PC_STEP && no_br && !pc_wr |=> PC_ADDR == $past(PC_ADDR) + 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("bad increment");
    property p_hold;
        !PC_STEP && no_br && !pc_wr |=> $stable(PC_ADDR);
    endproperty
    a_hold: assert property (p_hold) else $error("counter moved");
    property p_jump;
        JUMP && !CALL && !RET |=> PC_ADDR == {$past(PAGE_SEL), $past(BRANCH_ADDR)};
    endproperty
    a_jump: assert property (p_jump) else $error("bad jump target");
    property p_call;
        CALL && !RET |=> PC_ADDR[7:0] == 8'($past(BRANCH_ADDR))
            && PC_ADDR[11:8] == {$past(PAGE_SEL), 1'b0};
    endproperty
    a_call: assert property (p_call) else $error("bad call target");
    property p_pc_wr;
        pc_wr && no_br |=> PC_ADDR == {$past(PAGE_SEL), 1'b0, $past(WR_DATA)};
    endproperty
    a_pc_wr: assert property (p_pc_wr) else $error("bad low byte write");
    property p_rd_valid;
        1'b1 |=> RD_VALID == $past(RD_REQ);
    endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("bad read valid");
    property p_page;
        PAGE_WR ##1 1'b1 |-> PAGE_SEL == $past(PAGE_VAL);
    endproperty
    a_page: assert property (p_page) else $error("bad page bits");
    property p_bank;
        BANK_WR && !WR_REQ |=> BANK_PTR[6:4] == $past(BANK_VAL)
            && ((BANK_PTR ^ $past(BANK_PTR)) & 8'h8F) == 8'h00;
    endproperty
    a_bank: assert property (p_bank) else $error("bad bank write");
endmodule : pcsfa_top_props

bind pcsfa_top pcsfa_top_props i_props (
    .CLK(CLK), .RST(RST), .PC_STEP(PC_STEP), .JUMP(JUMP), .CALL(CALL), .RET(RET),
    .BRANCH_ADDR(BRANCH_ADDR), .PAGE_WR(PAGE_WR), .PAGE_VAL(PAGE_VAL),
    .BANK_WR(BANK_WR), .BANK_VAL(BANK_VAL), .DESIG(DESIG), .RD_REQ(RD_REQ),
    .WR_REQ(WR_REQ), .WR_DATA(WR_DATA), .RD_VALID(RD_VALID), .PC_ADDR(PC_ADDR),
    .PAGE_SEL(PAGE_SEL), .BANK_PTR(BANK_PTR)
);

// [tb/pcsfa_decode_model.sv]
`timescale 1ns/100ps

// ------------------------------------------------
// decode stand-in: one instruction per call
// ------------------------------------------------
module pcsfa_decode_model (
    // clock
    input  logic       clk,
    // flow and page or bank strobes
    output logic       step,
    output logic       jump,
    output logic       call,
    output logic       ret,
    output logic [8:0] br_addr,
    output logic       page_wr,
    output logic [2:0] page_val,
    output logic       bank_wr,
    output logic [2:0] bank_val,
    // operand access
    output logic [4:0] desig,
    output logic       rd_req,
    output logic       wr_req,
    output logic [7:0] wr_data
);
    // quiet at time zero
    initial
    begin
        {step, jump, call, ret, br_addr, page_wr, page_val} = '0;
        {bank_wr, bank_val, desig, rd_req, wr_req, wr_data} = '0;
    end

    // every strobe is set once per call, so it stands one cycle unless reissued;
    // flow and acc flip the unused wr_data or br_addr so a stale value is never mistaken for a live one
    task automatic flow(input logic [3:0] f, input logic [8:0] a);
        @(posedge clk);
        #2;
        {ret, call, jump, step} = f;
        br_addr = a;
        {page_wr, bank_wr, rd_req, wr_req} = 4'h0;
        wr_data = ~wr_data;
    endtask : flow

    task automatic acc(input logic r, input logic w, input logic [4:0] d,
                       input logic [7:0] wd);
        @(posedge clk);
        #2;
        {ret, call, jump, step, page_wr, bank_wr} = 6'h00;
        {rd_req, wr_req, desig, wr_data} = {r, w, d, wd};
        br_addr = ~br_addr;
    endtask : acc

    task automatic pb(input logic pw, input logic [2:0] pv, input logic bw,
                      input logic [2:0] bv);
        @(posedge clk);
        #2;
        {ret, call, jump, step, rd_req, wr_req} = 6'h00;
        {page_wr, page_val, bank_wr, bank_val} = {pw, pv, bw, bv};
    endtask : pb
endmodule : pcsfa_decode_model

// [tb/pcsfa_top_bench.sv]
`timescale 1ns/100ps

// ------------------------------------------------
// bench for counter, call stack and addressing
// ------------------------------------------------
module pcsfa_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        step, jump, call, ret, page_wr, bank_wr, rd_req, wr_req, rd_valid;
    logic [8:0]  br_addr;
    logic [2:0]  page_val, bank_val, page_sel;
    logic [4:0]  desig;
    logic [7:0]  wr_data, rd_data, bank_ptr;
    logic [11:0] pc;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          i;

    always #12.5 clk = ~clk;

    pcsfa_top i_dut (
        .CLK(clk), .RST(rst), .PC_STEP(step), .JUMP(jump), .CALL(call), .RET(ret),
        .BRANCH_ADDR(br_addr), .PAGE_WR(page_wr), .PAGE_VAL(page_val),
        .BANK_WR(bank_wr), .BANK_VAL(bank_val), .DESIG(desig), .RD_REQ(rd_req),
        .WR_REQ(wr_req), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .PC_ADDR(pc), .PAGE_SEL(page_sel), .BANK_PTR(bank_ptr)
    );

    pcsfa_decode_model i_dec (
        .clk, .step, .jump, .call, .ret, .br_addr, .page_wr, .page_val,
        .bank_wr, .bank_val, .desig, .rd_req, .wr_req, .wr_data
    );

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic chk12(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk12

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        chk12(nm, {4'h0, e}, {4'h0, g});
    endtask : chk8

    // one access then a quiet cycle, so nothing is repeated by accident
    task automatic wr(input logic [4:0] d, input logic [7:0] v);
        i_dec.acc(1'b0, 1'b1, d, v);
        i_dec.flow(4'h0, 9'h000);
    endtask : wr

    task automatic rd(input logic [4:0] d, input logic [7:0] e);
        i_dec.acc(1'b1, 1'b0, d, 8'h00);
        i_dec.flow(4'h0, 9'h000);
        chk8("rd_valid", 8'h01, {7'h00, rd_valid});
        chk8("rd_data", e, rd_data);
    endtask : rd

    task automatic give_verdict();
        $display("counts: compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (5) @(posedge clk);
        #2;
        rst = 1'b0;
        chk12("pc", 12'hFFF, pc);
        chk8("ptr", 8'h00, bank_ptr);
        rd(5'h02, 8'hFF);
        i_dec.flow(4'h1, 9'h000);
        i_dec.flow(4'h0, 9'h000);
        chk12("pc", 12'h000, pc);
        $display("test reset and wrap done");
        // page 5 jump to a page end, then count across it
        i_dec.pb(1'b1, 3'h5, 1'b0, 3'h0);
        i_dec.flow(4'h2, 9'h1FF);
        i_dec.flow(4'h1, 9'h000);
        i_dec.flow(4'h0, 9'h000);
        chk12("pc", 12'hC00, pc);
        chk8("page", 8'h05, {5'h00, page_sel});
        rd(5'h03, 8'hA0);
        wr(5'h02, 8'h80);
        chk12("pc", 12'hA80, pc);
        $display("test page and jump done");
        // nine calls overflow the stack; bit 8 of each target is dropped
        for (i = 0; i < 9; i++)
            i_dec.flow(4'h4, 9'h101 + 9'(i * 16));
        i_dec.flow(4'h0, 9'h000);
        chk12("pc", 12'hA81, pc);
        for (i = 0; i < 9; i++)
        begin
            i_dec.flow(4'h8, 9'h000);
            i_dec.flow(4'h0, 9'h000);
            chk12("ret pc", 12'hA02 + 12'((i < 8 ? 7 - i : 0) * 16), pc);
        end
        $display("test call stack done");
        // every addressing mode lands where the designator says
        // status write moves the page bits; its low bits are not stored
        wr(5'h03, 8'h7F);
        chk8("page", 8'h03, {5'h00, page_sel});
        rd(5'h03, 8'h60);
        wr(5'h04, 8'hF5);
        wr(5'h05, 8'hA5);
        wr(5'h00, 8'h3C);
        rd(5'h15, 8'h3C);
        wr(5'h04, 8'h05);
        rd(5'h00, 8'hA5);
        wr(5'h0F, 8'h11);
        wr(5'h04, 8'h00);
        wr(5'h1F, 8'h77);
        rd(5'h00, 8'h00);
        wr(5'h04, 8'h0F);
        rd(5'h1F, 8'h77);
        rd(5'h00, 8'h11);
        wr(5'h04, 8'h8F);
        i_dec.pb(1'b0, 3'h0, 1'b1, 3'h2);
        i_dec.flow(4'h0, 9'h000);
        chk8("ptr", 8'hAF, bank_ptr);
        wr(5'h13, 8'h5A);
        wr(5'h04, 8'h2F);
        wr(5'h13, 8'hC3);
        wr(5'h04, 8'hAF);
        rd(5'h13, 8'h5A);
        $display("test addressing done");
        give_verdict();
    end
endmodule : pcsfa_top_bench
